// [rtl/rfr_pkg.sv]
package rfr_pkg;

   localparam int unsigned NUM_SRC = 16;

   // command bytes on the link
   localparam logic [7:0] OP_CONFIG   = 8'h8d;
   localparam logic [7:0] OP_READ     = 8'h15;
   localparam logic [7:0] OP_CLEAR    = 8'h97;
   localparam logic [7:0] LEN_CONFIG  = 8'h08;
   localparam logic [7:0] LEN_READ    = 8'h02;
   localparam logic [7:0] LEN_CLEAR   = 8'h02;
   localparam logic [7:0] STATUS_FILL = 8'h00;
   localparam logic [7:0] FILL_BYTE   = 8'h00;

   // frame layout, byte indices from the opcode at 0
   localparam logic [3:0] HDR_PLAIN   = 4'h1;
   localparam logic [3:0] HDR_LEN     = 4'h2;
   localparam logic [3:0] RD_HI_IDX   = 4'h2;
   localparam logic [3:0] RD_LO_IDX   = 4'h3;
   localparam logic [3:0] CFG_BYTES   = 4'h8;
   localparam logic [3:0] CLR_BYTES   = 4'h2;
   localparam logic [3:0] RD_LAST_IDX = 4'h3;
   localparam logic [2:0] LAST_BIT    = 3'h7;

   // flag bit positions
   localparam int unsigned BIT_TX_DONE       = 0;
   localparam int unsigned BIT_RX_DONE       = 1;
   localparam int unsigned BIT_SYNC_OK       = 2;
   localparam int unsigned BIT_SYNC_BAD      = 3;
   localparam int unsigned BIT_HEADER_OK     = 4;
   localparam int unsigned BIT_HEADER_BAD    = 5;
   localparam int unsigned BIT_CHECKSUM_FAIL = 6;
   localparam int unsigned BIT_RESP_DONE     = 7;
   localparam int unsigned BIT_RESP_DROPPED  = 8;
   localparam int unsigned BIT_INIT_RESULT   = 9;
   localparam int unsigned BIT_INIT_TIMEOUT  = 10;
   localparam int unsigned BIT_RESP_REQ_OK   = 11;
   localparam int unsigned BIT_CHAN_DONE     = 12;
   localparam int unsigned BIT_CHAN_SEEN     = 13;
   localparam int unsigned BIT_XFER_TIMEOUT  = 14;
   localparam int unsigned BIT_PREAMBLE      = 15;

   // controller registers, byte addresses
   localparam logic [11:0] REG_ENABLE   = 12'h000;
   localparam logic [11:0] REG_ROUTE1   = 12'h004;
   localparam logic [11:0] REG_ROUTE2   = 12'h008;
   localparam logic [11:0] REG_ROUTE3   = 12'h00c;
   localparam logic [11:0] REG_CLEAR    = 12'h010;
   localparam logic [11:0] REG_CMD      = 12'h014;
   localparam logic [11:0] REG_STATUS   = 12'h018;
   localparam logic [11:0] REG_FLAGS    = 12'h01c;
   localparam logic [11:0] REG_IRQ_STAT = 12'h020;
   localparam logic [11:0] REG_IRQ_MASK = 12'h024;
   localparam logic [11:0] REG_MODE     = 12'h028;

   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [3:0]  IRQ_RESET  = 4'h0;
   localparam int unsigned IRQ_DONE   = 0;

   typedef enum logic [1:0] {
      RFR_CMD_NONE   = 2'h0,
      RFR_CMD_CONFIG = 2'h1,
      RFR_CMD_READ   = 2'h2,
      RFR_CMD_CLEAR  = 2'h3
   } rfr_cmd_e;

endpackage

// [rtl/rfr_link_if.sv]
`timescale 1ns/1ps
interface rfr_link_if;
   logic       sclk;
   logic       cs_n;
   logic       mosi;
   logic       miso;
   logic       len_mode;
   logic [2:0] ev_pin;

   modport dev (input sclk, cs_n, mosi, len_mode, output miso, ev_pin);
   modport host (output sclk, cs_n, mosi, len_mode, input miso, ev_pin);
endinterface

// [rtl/rfr_device.sv]
// Contract
// RULE_01 - sixteen sources, each enabled and routable
// RULE_02 - events logged in 16-bit flag register
// RULE_03 - flag bits 0-6 and 14 fixed
// RULE_04 - ranging events on bits 7 to 11
// RULE_05 - channel check done and seen bits 12-13
// RULE_06 - preamble flag only with long preamble on
// RULE_07 - config opcode plus eight mask bytes
// RULE_08 - rising edge logs only when enabled
// RULE_09 - routed pin rises with the flag
// RULE_10 - pin is OR of routed flags; the code ORs only routed flags whose source is set in en_r
// RULE_11 - read: two status bytes, flags high first
// RULE_12 - length-byte read returns flags high first
// RULE_13 - clear opcode plus two-byte clear mask
// RULE_14 - ones clear flags, zeros keep them
// RULE_15 - single-source pin falls when flag cleared
// RULE_16 - shared pin stays high until all cleared
// RULE_17 - reset zeroes flags, masks and pins
`timescale 1ns/1ps
module rfr_device #(
   parameter int unsigned SRC_W = 16
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // event sources from the radio, same clock
   input  wire logic [SRC_W-1:0] event_src,
   input  wire logic             long_preamble_on,
   // command link and event pins
   rfr_link_if.dev               link,
   // flag register for local observation
   output logic      [SRC_W-1:0] event_flags_value
);

   if (SRC_W != rfr_pkg::NUM_SRC)
   begin : g_chk
      $error("rfr_device: SRC_W must be 16");
   end

   // link synchronisers; stage 0 feeds stage 1 only
   logic [1:0]       sclk_s_r;
   logic [1:0]       cs_s_r;
   logic [1:0]       mosi_s_r;
   logic [1:0]       len_s_r;
   logic             sclk_d_r;
   logic             rise;
   logic             fall;

   logic [2:0]       bit_cnt_r;
   logic [3:0]       byte_cnt_r;
   logic [6:0]       rx_sh_r;
   logic [7:0]       op_r;
   logic [55:0]      par_sh_r;
   logic [SRC_W-1:0] snap_r;
   logic [7:0]       rx_byte;
   logic [7:0]       tx_cur;
   logic [63:0]      new_par;
   logic [3:0]       hdr;
   logic             byte_done;
   logic             cfg_wr;
   logic             clr_wr;

   logic [SRC_W-1:0] flags_r;
   logic [SRC_W-1:0] flags_nxt;
   logic [SRC_W-1:0] src_q_r;
   logic [SRC_W-1:0] en_r;
   logic [SRC_W-1:0] route_r [3];
   logic [SRC_W-1:0] set_v;
   logic [SRC_W-1:0] clr_v;
   logic [SRC_W-1:0] gate_v;
   logic [2:0]       pin_nxt;

   // byte the device sends at a given frame position
   function automatic logic [7:0] tx_byte(input logic [3:0]       idx,
                                          input logic [7:0]       op,
                                          input logic [SRC_W-1:0] snap);
      logic [7:0] b;
      b = rfr_pkg::STATUS_FILL;
      if (op == rfr_pkg::OP_READ && idx == rfr_pkg::RD_HI_IDX)
         b = snap[15:8]; // RULE_11 RULE_12
      if (op == rfr_pkg::OP_READ && idx == rfr_pkg::RD_LO_IDX)
         b = snap[7:0]; // RULE_11 RULE_12
      return b;
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_s_r <= 2'h0;
         cs_s_r   <= 2'h3;
         mosi_s_r <= 2'h0;
         len_s_r  <= 2'h0;
         sclk_d_r <= 1'b0;
      end
      else
      begin
         sclk_s_r <= {sclk_s_r[0], link.sclk};
         cs_s_r   <= {cs_s_r[0], link.cs_n};
         mosi_s_r <= {mosi_s_r[0], link.mosi};
         len_s_r  <= {len_s_r[0], link.len_mode};
         sclk_d_r <= sclk_s_r[1];
      end
   end

   assign rise      = sclk_s_r[1] & ~sclk_d_r & ~cs_s_r[1];
   assign fall      = ~sclk_s_r[1] & sclk_d_r & ~cs_s_r[1];
   assign rx_byte   = {rx_sh_r, mosi_s_r[1]};
   assign tx_cur    = tx_byte(byte_cnt_r, op_r, snap_r);
   assign new_par   = {par_sh_r, rx_byte};
   assign byte_done = rise && bit_cnt_r == rfr_pkg::LAST_BIT;
   // the length byte shifts parameters one place back
   assign hdr       = len_s_r[1] ? rfr_pkg::HDR_LEN : rfr_pkg::HDR_PLAIN; // RULE_07 RULE_13

   assign cfg_wr = byte_done && op_r == rfr_pkg::OP_CONFIG
                   && byte_cnt_r == 4'(hdr + rfr_pkg::CFG_BYTES - 4'h1); // RULE_07
   assign clr_wr = byte_done && op_r == rfr_pkg::OP_CLEAR
                   && byte_cnt_r == 4'(hdr + rfr_pkg::CLR_BYTES - 4'h1); // RULE_13

   // bit and byte position inside a frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 4'h0;
         rx_sh_r    <= 7'h00;
      end
      else if (cs_s_r[1])
      begin
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 4'h0;
      end
      else if (rise)
      begin
         rx_sh_r   <= rx_byte[6:0];
         bit_cnt_r <= bit_cnt_r + 3'h1;
         // saturate so overlong frames never wrap onto a decode index
         if (bit_cnt_r == rfr_pkg::LAST_BIT && byte_cnt_r != 4'hf)
            byte_cnt_r <= byte_cnt_r + 4'h1;
      end
   end

   // opcode, parameter bytes and read snapshot
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_r     <= 8'h00;
         par_sh_r <= 56'h0;
         snap_r   <= rfr_pkg::MASK_RESET;
      end
      else if (cs_s_r[1])
         op_r <= 8'h00;
      else if (byte_done)
      begin
         if (byte_cnt_r == 4'h0)
         begin
            op_r   <= rx_byte;
            // one snapshot keeps high and low bytes coherent
            snap_r <= flags_r; // RULE_11 RULE_12
         end
         else if (byte_cnt_r >= hdr)
            par_sh_r <= new_par[55:0];
      end
   end

   // reply shifts out msb first, changed on the falling edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         link.miso <= 1'b0;
      else if (cs_s_r[1])
         link.miso <= 1'b0;
      else if (fall)
         link.miso <= tx_cur[~bit_cnt_r]; // RULE_11
   end

   // enable and route masks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_r       <= rfr_pkg::MASK_RESET; // RULE_17
         route_r[0] <= rfr_pkg::MASK_RESET;
         route_r[1] <= rfr_pkg::MASK_RESET;
         route_r[2] <= rfr_pkg::MASK_RESET;
      end
      else if (cfg_wr)
      begin
         en_r       <= new_par[63:48]; // RULE_07 RULE_01
         route_r[0] <= new_par[47:32];
         route_r[1] <= new_par[31:16];
         route_r[2] <= new_par[15:0];
      end
   end

   // bit 15 has no source unless the long preamble is active
   always_comb
   begin
      gate_v = '1;
      gate_v[rfr_pkg::BIT_PREAMBLE] = long_preamble_on; // RULE_06
   end

   // sources sit at their fixed bit positions, bits 0..15
   assign set_v     = event_src & ~src_q_r & en_r & gate_v; // RULE_08 RULE_03 RULE_04 RULE_05
   assign clr_v     = clr_wr ? new_par[15:0] : rfr_pkg::MASK_RESET; // RULE_14
   // an event arriving with its clear is kept
   assign flags_nxt = (flags_r & ~clr_v) | set_v; // RULE_02 RULE_14

   always_comb
   begin
      for (int i = 0; i < 3; i++)
         pin_nxt[i] = |(flags_nxt & en_r & route_r[i]); // RULE_10 RULE_15 RULE_16
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_q_r           <= rfr_pkg::MASK_RESET;
         flags_r           <= rfr_pkg::MASK_RESET; // RULE_17
         event_flags_value <= rfr_pkg::MASK_RESET;
      end
      else
      begin
         src_q_r           <= event_src;
         flags_r           <= flags_nxt;
         event_flags_value <= flags_nxt;
      end
   end

   // pins derive from the next flags so they rise on the logging edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         link.ev_pin <= 3'h0; // RULE_17
      else
         link.ev_pin <= pin_nxt; // RULE_09
   end

endmodule

// [rtl/rfr_host.sv]
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module rfr_host #(
   parameter int unsigned HALF_DIV = 8
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt
   output logic             irq,
   // link to the device
   rfr_link_if.host         link
);

   if (HALF_DIV < 8 || HALF_DIV > 255)
   begin : g_chk
      $error("rfr_host: HALF_DIV must be 8..255");
   end

   typedef enum logic [1:0] {
      RFR_H_IDLE = 2'b00,
      RFR_H_LOW  = 2'b01,
      RFR_H_HIGH = 2'b11,
      RFR_H_END  = 2'b10
   } rfr_hstate_e;

   rfr_hstate_e       st_r;
   rfr_pkg::rfr_cmd_e cmd_r;
   logic [15:0]       en_r;
   logic [15:0]       rt1_r;
   logic [15:0]       rt2_r;
   logic [15:0]       rt3_r;
   logic [15:0]       clr_r;
   logic [15:0]       flags_r;
   logic              mode_r;
   logic              start_r;
   logic [3:0]        istat_r;
   logic [3:0]        imask_r;
   logic [3:0]        istat_nxt;
   logic [3:0]        ev;
   logic [1:0]        miso_s_r;
   logic [2:0]        pin_s0_r;
   logic [2:0]        pin_s1_r;
   logic [2:0]        pin_d_r;
   logic [7:0]        div_r;
   logic              tick;
   logic [3:0]        idx_r;
   logic [2:0]        hbit_r;
   logic [7:0]        rx_sh_r;
   logic [7:0]        cur;
   logic [7:0]        op_b;
   logic [7:0]        nxt;
   logic              access;
   logic              wr;
   logic              done;

   // byte the host sends at frame position k
   function automatic logic [7:0] hbyte(input rfr_pkg::rfr_cmd_e c,
                                        input logic [3:0] k,
                                        input logic       lm,
                                        input logic [63:0] cfg,
                                        input logic [15:0] clr);
      logic [3:0] p;
      p = k - (lm ? rfr_pkg::HDR_LEN : rfr_pkg::HDR_PLAIN);
      hbyte = rfr_pkg::FILL_BYTE;
      if (k == 4'h0)
         hbyte = c == rfr_pkg::RFR_CMD_CONFIG ? rfr_pkg::OP_CONFIG :
                 c == rfr_pkg::RFR_CMD_READ ? rfr_pkg::OP_READ : rfr_pkg::OP_CLEAR;
      else if (lm && k == 4'h1)
         hbyte = c == rfr_pkg::RFR_CMD_CONFIG ? rfr_pkg::LEN_CONFIG :
                 c == rfr_pkg::RFR_CMD_READ ? rfr_pkg::LEN_READ : rfr_pkg::LEN_CLEAR;
      else if (c == rfr_pkg::RFR_CMD_CONFIG)
         hbyte = cfg[8*(7-p[2:0]) +: 8];
      else if (c == rfr_pkg::RFR_CMD_CLEAR)
         hbyte = clr[8*(1-p[0]) +: 8];
   endfunction

   function automatic logic [3:0] last_idx(input rfr_pkg::rfr_cmd_e c, input logic lm);
      logic [3:0] h;
      h = lm ? rfr_pkg::HDR_LEN : rfr_pkg::HDR_PLAIN;
      if (c == rfr_pkg::RFR_CMD_CONFIG)
         last_idx = 4'(h + rfr_pkg::CFG_BYTES - 4'h1);
      else if (c == rfr_pkg::RFR_CMD_CLEAR)
         last_idx = 4'(h + rfr_pkg::CLR_BYTES - 4'h1);
      else
         last_idx = rfr_pkg::RD_LAST_IDX;
   endfunction

   assign access = psel & penable & ~pready;
   // a write lands on the edge that completes the transfer, not earlier
   assign wr     = psel & penable & pready & pwrite;
   assign cur    = hbyte(cmd_r, idx_r, mode_r, {en_r, rt1_r, rt2_r, rt3_r}, clr_r);
   assign op_b   = hbyte(cmd_r, 4'h0, mode_r, 64'h0, 16'h0);
   assign nxt    = hbyte(cmd_r, 4'(idx_r + 4'h1), mode_r, {en_r, rt1_r, rt2_r, rt3_r}, clr_r);
   assign tick   = div_r == 8'(HALF_DIV - 1);
   assign done   = st_r == RFR_H_END && tick;

   // apb: one wait state, answer registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= access;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         if (access)
            unique case (paddr)
               rfr_pkg::REG_ENABLE:   prdata <= {16'h0, en_r};
               rfr_pkg::REG_ROUTE1:   prdata <= {16'h0, rt1_r};
               rfr_pkg::REG_ROUTE2:   prdata <= {16'h0, rt2_r};
               rfr_pkg::REG_ROUTE3:   prdata <= {16'h0, rt3_r};
               rfr_pkg::REG_CLEAR:    prdata <= {16'h0, clr_r};
               rfr_pkg::REG_CMD:      prdata <= {30'h0, cmd_r};
               rfr_pkg::REG_STATUS:
                  prdata <= {28'h0, pin_s1_r, start_r | (st_r != RFR_H_IDLE)};
               rfr_pkg::REG_FLAGS:    prdata <= {16'h0, flags_r};
               rfr_pkg::REG_IRQ_STAT: prdata <= {28'h0, istat_r};
               rfr_pkg::REG_IRQ_MASK: prdata <= {28'h0, imask_r};
               rfr_pkg::REG_MODE:     prdata <= {31'h0, mode_r};
               default:               pslverr <= 1'b1;
            endcase
      end
   end

   // software registers; a command write while busy is ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_r    <= rfr_pkg::MASK_RESET;
         rt1_r   <= rfr_pkg::MASK_RESET;
         rt2_r   <= rfr_pkg::MASK_RESET;
         rt3_r   <= rfr_pkg::MASK_RESET;
         clr_r   <= rfr_pkg::MASK_RESET;
         imask_r <= rfr_pkg::IRQ_RESET;
         mode_r  <= 1'b0;
         cmd_r   <= rfr_pkg::RFR_CMD_NONE;
         start_r <= 1'b0;
      end
      else
      begin
         if (st_r == RFR_H_IDLE)
            start_r <= 1'b0;
         if (wr)
         begin
            if (paddr == rfr_pkg::REG_ENABLE)   en_r    <= pwdata[15:0];
            if (paddr == rfr_pkg::REG_ROUTE1)   rt1_r   <= pwdata[15:0];
            if (paddr == rfr_pkg::REG_ROUTE2)   rt2_r   <= pwdata[15:0];
            if (paddr == rfr_pkg::REG_ROUTE3)   rt3_r   <= pwdata[15:0];
            if (paddr == rfr_pkg::REG_CLEAR)    clr_r   <= pwdata[15:0];
            if (paddr == rfr_pkg::REG_IRQ_MASK) imask_r <= pwdata[3:0];
            if (paddr == rfr_pkg::REG_MODE)     mode_r  <= pwdata[0];
            if (paddr == rfr_pkg::REG_CMD && !start_r && st_r == RFR_H_IDLE
                && pwdata[1:0] != rfr_pkg::RFR_CMD_NONE)
            begin
               cmd_r   <= rfr_pkg::rfr_cmd_e'(pwdata[1:0]);
               start_r <= 1'b1;
            end
         end
      end
   end

   // frame engine: mode 0, msb first, sclk made by dividing pclk
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r          <= RFR_H_IDLE;
         div_r         <= 8'h0;
         idx_r         <= 4'h0;
         hbit_r        <= 3'h0;
         rx_sh_r       <= 8'h0;
         flags_r       <= rfr_pkg::MASK_RESET;
         link.sclk     <= 1'b0;
         link.cs_n     <= 1'b1;
         link.mosi     <= 1'b0;
         link.len_mode <= 1'b0;
      end
      else
      begin
         link.len_mode <= mode_r;
         div_r <= (st_r == RFR_H_IDLE || tick) ? 8'h0 : div_r + 8'h1;
         unique case (st_r)
            RFR_H_IDLE:
               if (start_r)
               begin
                  link.cs_n <= 1'b0;
                  idx_r     <= 4'h0;
                  hbit_r    <= 3'h0;
                  link.mosi <= op_b[7]; // RULE_07 RULE_11
                  st_r      <= RFR_H_LOW;
               end
            RFR_H_LOW:
               if (tick)
               begin
                  link.sclk <= 1'b1;
                  rx_sh_r   <= {rx_sh_r[6:0], miso_s_r[1]};
                  st_r      <= RFR_H_HIGH;
               end
            RFR_H_HIGH:
               if (tick)
               begin
                  link.sclk <= 1'b0;
                  st_r      <= RFR_H_LOW;
                  hbit_r    <= hbit_r + 3'h1;
                  link.mosi <= cur[~(hbit_r + 3'h1)];
                  if (hbit_r == rfr_pkg::LAST_BIT)
                  begin
                     if (cmd_r == rfr_pkg::RFR_CMD_READ && idx_r == rfr_pkg::RD_HI_IDX)
                        flags_r[15:8] <= rx_sh_r; // RULE_11 RULE_12
                     if (cmd_r == rfr_pkg::RFR_CMD_READ && idx_r == rfr_pkg::RD_LO_IDX)
                        flags_r[7:0] <= rx_sh_r;
                     idx_r     <= idx_r + 4'h1;
                     link.mosi <= nxt[7]; // RULE_13
                     if (idx_r == last_idx(cmd_r, mode_r))
                     begin
                        link.mosi <= 1'b0;
                        st_r      <= RFR_H_END;
                     end
                  end
               end
            RFR_H_END:
               if (tick)
               begin
                  link.cs_n <= 1'b1;
                  st_r      <= RFR_H_IDLE;
               end
         endcase
      end
   end

   // pin and reply synchronisers, interrupt status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         miso_s_r <= 2'h0;
         pin_s0_r <= 3'h0;
         pin_s1_r <= 3'h0;
         pin_d_r  <= 3'h0;
         istat_r  <= rfr_pkg::IRQ_RESET;
         irq      <= 1'b0;
      end
      else
      begin
         miso_s_r <= {miso_s_r[0], link.miso};
         pin_s0_r <= link.ev_pin;
         pin_s1_r <= pin_s0_r;
         pin_d_r  <= pin_s1_r;
         istat_r  <= istat_nxt;
         irq      <= |(istat_nxt & imask_r);
      end
   end

   assign ev = {pin_s1_r & ~pin_d_r, done};
   // a new event outweighs a same-cycle write-one clear
   assign istat_nxt = (istat_r & ~((wr && paddr == rfr_pkg::REG_IRQ_STAT) ? pwdata[3:0]
                                                                           : 4'h0)) | ev;

endmodule

// [verification/rfr_sva.sv]
`timescale 1ns/1ps
module rfr_sva (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // link
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        mosi,
   input wire logic        miso,
   input wire logic        len_mode,
   input wire logic [2:0]  ev_pin,
   // device side
   input wire logic [15:0] event_flags_value,
   input wire logic [15:0] event_src,
   input wire logic        long_preamble_on
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_lead;
      (!cs_n && !sclk) [*8];
   endsequence
   sequence s_high;
      sclk [*8] ##1 !sclk;
   endsequence

   a_reset_clear: assert property ($rose(presetn) |->
      ev_pin == 3'h0 && event_flags_value == 16'h0 && cs_n) else $error("reset state wrong");
   a_flag_cause: assert property (((event_flags_value & ~$past(event_flags_value)) &
      ~($past(event_src) & ~$past(event_src, 2))) == 16'h0) else $error("flag without edge");
   a_flag_sticky: assert property (cs_n && $past(cs_n) |->
      ($past(event_flags_value) & ~event_flags_value) == 16'h0) else $error("flag lost");
   a_pin_needs_flag: assert property (|ev_pin && |$past(ev_pin) |->
      $past(event_flags_value) != 16'h0) else $error("pin high without flag");
   a_pin_hold: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |->
      ($past(ev_pin) & ~ev_pin) == 3'h0) else $error("pin fell outside frame");
   a_pin_rise_cause: assert property (cs_n && $past(cs_n) && |(ev_pin & ~$past(ev_pin)) |->
      |(event_flags_value & ~$past(event_flags_value))) else $error("pin rose alone");
   a_preamble_gate: assert property ($rose(event_flags_value[15]) |->
      $past(long_preamble_on)) else $error("preamble flag while gated");
   a_sclk_half: assert property ($rose(sclk) |-> s_high)
      else $error("link clock half period wrong");
   a_cs_lead: assert property ($fell(cs_n) |-> s_lead)
      else $error("frame lead time wrong");
   a_miso_idle: assert property (cs_n |-> !miso)
      else $error("reply data outside frame");
   a_sclk_idle: assert property (cs_n |-> !sclk)
      else $error("link clock outside frame");
   a_mosi_edge: assert property (!cs_n && !$past(cs_n) && $changed(mosi) |->
      $fell(sclk)) else $error("data moved off falling edge");
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [15:0] src;
   logic        lpo;
   logic [15:0] flags;
   logic [15:0] e;
   logic [31:0] rd;
   logic        er;
   int          err_total;
   int          n_tests;
   int          k;

   rfr_link_if lk();
   rfr_device u_rfr_device (.pclk(pclk), .presetn(presetn), .event_src(src),
      .long_preamble_on(lpo), .link(lk), .event_flags_value(flags));
   rfr_host u_rfr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .link(lk));
   rfr_sva u_rfr_sva (.pclk(pclk), .presetn(presetn), .sclk(lk.sclk), .cs_n(lk.cs_n),
      .mosi(lk.mosi), .miso(lk.miso), .len_mode(lk.len_mode), .ev_pin(lk.ev_pin),
      .event_flags_value(flags), .event_src(src), .long_preamble_on(lpo));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic give_verdict;
      if (err_total == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // starts a frame and polls busy; a frame that never ends counts as a mismatch
   task automatic run(input logic [1:0] c);
      int t;
      apb(1'b1, rfr_pkg::REG_CMD, {30'h0, c});
      t = 0;
      do
      begin
         apb(1'b0, rfr_pkg::REG_STATUS, 32'h0);
         t++;
      end
      while (rd[0] !== 1'b0 && t < 1000);
      chk("busy", 32'h0, rd & 32'h1);
      repeat (4) @(posedge pclk);
   endtask

   task automatic pulse(input logic [15:0] m);
      @(posedge pclk);
      src <= m;
      @(posedge pclk);
      src <= 16'h0;
      repeat (3) @(posedge pclk);
   endtask

   initial
   begin
      #100000;
      err_total++;
      give_verdict;
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      src = 16'h0;
      lpo = 1'b0;
      err_total = 0;
      n_tests = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk("pins", 32'h0, {29'h0, lk.ev_pin});
      chk("flags", 32'h0, {16'h0, flags});
      apb(1'b0, rfr_pkg::REG_ROUTE3, 32'h0);
      chk("route3", 32'h0, rd);
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1'b1, rfr_pkg::REG_IRQ_MASK, 32'h1);
      apb(1'b1, rfr_pkg::REG_ENABLE, 32'hbfff);
      apb(1'b1, rfr_pkg::REG_ROUTE1, 32'h0001);
      apb(1'b1, rfr_pkg::REG_ROUTE2, 32'h0003);
      apb(1'b1, rfr_pkg::REG_ROUTE3, 32'h0001);
      run(2'h1);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, rfr_pkg::REG_IRQ_STAT, 32'hf);
      repeat (2) @(posedge pclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      e = 16'h0;
      for (k = 0; k < 16; k++)
      begin
         pulse(16'h1 << k);
         e = e | ((16'h1 << k) & 16'h3fff);
         chk("flags", {16'h0, e}, {16'h0, flags});
      end
      chk("pins", 32'h7, {29'h0, lk.ev_pin});
      lpo <= 1'b1;
      pulse(16'h8000);
      chk("preamble", 32'hbfff, {16'h0, flags});
      run(2'h2);
      apb(1'b0, rfr_pkg::REG_FLAGS, 32'h0);
      chk("read_spi", 32'hbfff, rd);
      apb(1'b1, rfr_pkg::REG_IRQ_MASK, 32'h0);
      apb(1'b1, rfr_pkg::REG_CLEAR, 32'h1);
      run(2'h3);
      chk("clr1", 32'hbffe, {16'h0, flags});
      chk("pins", 32'h2, {29'h0, lk.ev_pin});
      apb(1'b1, rfr_pkg::REG_MODE, 32'h1);
      apb(1'b1, rfr_pkg::REG_CLEAR, 32'h2);
      run(2'h3);
      chk("clr2", 32'hbffc, {16'h0, flags});
      chk("pins", 32'h0, {29'h0, lk.ev_pin});
      run(2'h2);
      apb(1'b0, rfr_pkg::REG_FLAGS, 32'h0);
      chk("read_len", 32'hbffc, rd);
      chk("irq_mask", 32'h0, {31'h0, irq});
      apb(1'b0, rfr_pkg::REG_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h1, rd & 32'h1);
      give_verdict;
   end
endmodule
